// file: clock_seq_pkg.sv
// Purpose: Shared constants for the clock generator start-up and SYSREF sequencer
// Assumes: 50 MHz core clock, 32-bit Avalon-MM register window
// Notes: Offsets are byte addresses of aligned words
package clock_seq_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CHAN_ENABLE = 8'h04;
  localparam logic [7:0] OFS_SYNC_ENABLE = 8'h08;
  localparam logic [7:0] OFS_PULSE_MODE = 8'h0C;
  localparam logic [7:0] OFS_SYSREF_TIMER = 8'h10;
  localparam logic [7:0] OFS_PULSE_COUNT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_RESTART = 0;
  localparam int CTL_RESEED = 1;
  localparam int CTL_PULSE = 2;
  localparam int STS_PLL2_LOCK = 0;
  localparam int STS_PLL1_LOCK = 1;
  localparam int STS_PHASE_OK = 2;
  localparam int STS_SYSREF_VALID = 3;
  localparam int STS_REF_PRESENT = 4;
  localparam int TIMER_W = 12;
  localparam int PULSE_W = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [11:0] TIMER_RESET = 12'h0_100;
  localparam logic [2:0] PULSE_COUNT_RESET = 3'h1;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CORE_CLK_MHZ = 50;
  localparam int PLL2_LOCK_NS = 50_000;
  localparam int PLL2_LOCK_CYC = PLL2_LOCK_NS * CORE_CLK_MHZ / 1000;
  localparam int PLL1_LOCK_MS = 50;
  localparam int PLL1_LOCK_CYC = PLL1_LOCK_MS * CORE_CLK_MHZ * 1000;
  localparam int PHASE_SETTLE_PERIODS = 6;
  localparam int REF_LOSS_CYC = 64;
endpackage

// file: sysref_bus_if.sv
// Purpose: Carries SYSREF timing and channel controls between sequencer and channel bank
// Assumes: Single core clock domain
// Notes: All signals are synchronous to core_clk
`timescale 1ns/1ns
interface sysref_bus_if #(parameter int NUM_CH = 14);
  logic reseed;
  logic pulseReq;
  logic [clock_seq_pkg::TIMER_W-1:0] timer;
  logic [clock_seq_pkg::PULSE_W-1:0] pulseCount;
  logic [NUM_CH-1:0] chanEn;
  logic [NUM_CH-1:0] syncEn;
  logic [NUM_CH-1:0] pulseMode;
  logic [NUM_CH-1:0] sysref;
  modport seq (output reseed, pulseReq, timer, pulseCount, chanEn, syncEn, pulseMode,
    input sysref);
  modport bank (input reseed, pulseReq, timer, pulseCount, chanEn, syncEn, pulseMode,
    output sysref);
endinterface

// file: sysref_channel_bank.sv
// Purpose: Per-channel SYSREF phase counters and pulse generators
// Assumes: Timer value of zero treated as one
// Notes: Channels outside the sync mask never see a reseed
`timescale 1ns/1ns
module sysref_channel_bank #(
  parameter int NUM_CH = 14
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  sysref_bus_if.bank bus
);
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      logic [clock_seq_pkg::TIMER_W-1:0] phase, next_phase;
      logic [clock_seq_pkg::PULSE_W-1:0] left, next_left;
      logic out, next_out;
      logic [clock_seq_pkg::TIMER_W-1:0] last;
      always_comb begin
        last = (bus.timer == '0) ? '0 : bus.timer - 1'b1;
        next_phase = (phase >= last) ? '0 : phase + 1'b1;
        if (bus.reseed && bus.syncEn[i]) begin
          next_phase = '0;
        end
        next_left = left;
        if ((bus.pulseReq || (bus.reseed && bus.syncEn[i]))
            && bus.chanEn[i] && bus.pulseMode[i]) begin
          next_left = bus.pulseCount;
        end else if (phase == last && left != '0) begin
          next_left = left - 1'b1;
        end
        next_out = bus.chanEn[i] && (!bus.pulseMode[i] || left != '0)
          && (phase < {1'b0, bus.timer[clock_seq_pkg::TIMER_W-1:1]});
      end
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          phase <= '0;
          left <= '0;
          out <= 1'b0;
        end else if (ce) begin
          phase <= next_phase;
          left <= next_left;
          out <= next_out;
        end
      end
      assign bus.sysref[i] = out;
    end
  endgenerate
endmodule // sysref_channel_bank

// file: clock_init_sequencer.sv
// Purpose: Device side of the start-up, SYSREF shutdown and resync sequence
// Assumes: Avalon-MM slave, one wait state on every access; refClk is asynchronous
// Notes: PLL lock is modelled by timers started on release of the restart bit
// Functional notes
// - Restart bit written 1 then 0 resets lock timers and starts calibration.
// - PLL1 locks in parallel while PLL2 calibrates, PLL2 in about 50 us.
// - Reseed request aligns divider phases and starts initial pulse stream.
// - Phase status reads 1 once all outputs reach their phases.
// - Pulse generator request emits pulse chain on pulse-mode channels.
// - Channels with sync mask cleared ignore reseed, keep running.
// - SYSREF-valid flag is pollable and also drives a general output pin.
`timescale 1ns/1ns
module clock_init_sequencer #(
  parameter int NUM_CH = 14,
  parameter int PLL1_LOCK_CYCLES = clock_seq_pkg::PLL1_LOCK_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic refClk,
  output logic [NUM_CH-1:0] sysrefOut,
  output logic generalOutputPin
);
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_CAL = 3'b010,
    ST_RUN = 3'b100
  } cal_state_t;

  sysref_bus_if #(.NUM_CH(NUM_CH)) bus ();

  // ----------------------------------------
  // Register file and bus slave
  // ----------------------------------------
  logic restart, next_restart;
  logic reseedPulse, next_reseedPulse;
  logic pulsePulse, next_pulsePulse;
  logic [NUM_CH-1:0] chanEn, next_chanEn;
  logic [NUM_CH-1:0] syncEn, next_syncEn;
  logic [NUM_CH-1:0] pulseMode, next_pulseMode;
  logic [11:0] timer, next_timer;
  logic [2:0] pulseCount, next_pulseCount;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [31:0] statusWord;
  logic wrTake;

  function automatic logic [31:0] readMux(input logic [7:0] a, input logic [31:0] sts,
                                          input logic rs);
    logic [31:0] r;
    r = '0;
    unique case (a)
      clock_seq_pkg::OFS_CONTROL: r[clock_seq_pkg::CTL_RESTART] = rs;
      clock_seq_pkg::OFS_CHAN_ENABLE: r[NUM_CH-1:0] = chanEn;
      clock_seq_pkg::OFS_SYNC_ENABLE: r[NUM_CH-1:0] = syncEn;
      clock_seq_pkg::OFS_PULSE_MODE: r[NUM_CH-1:0] = pulseMode;
      clock_seq_pkg::OFS_SYSREF_TIMER: r[11:0] = timer;
      clock_seq_pkg::OFS_PULSE_COUNT: r[2:0] = pulseCount;
      clock_seq_pkg::OFS_STATUS: r = sts;
      default: r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    // A write lands on the edge where the master sees waitrequest low
    wrTake = write && !waitrequest;
    next_waitrequest = !((read || write) && waitrequest);
    next_readdata = readdata;
    if (read && waitrequest) begin
      next_readdata = readMux(address, statusWord, restart);
    end
    next_restart = restart;
    next_reseedPulse = 1'b0;
    next_pulsePulse = 1'b0;
    next_chanEn = chanEn;
    next_syncEn = syncEn;
    next_pulseMode = pulseMode;
    next_timer = timer;
    next_pulseCount = pulseCount;
    if (wrTake) begin
      unique case (address)
        clock_seq_pkg::OFS_CONTROL: begin
          next_restart = writedata[clock_seq_pkg::CTL_RESTART];
          next_reseedPulse = writedata[clock_seq_pkg::CTL_RESEED];
          next_pulsePulse = writedata[clock_seq_pkg::CTL_PULSE];
        end
        clock_seq_pkg::OFS_CHAN_ENABLE: next_chanEn = writedata[NUM_CH-1:0];
        clock_seq_pkg::OFS_SYNC_ENABLE: next_syncEn = writedata[NUM_CH-1:0];
        clock_seq_pkg::OFS_PULSE_MODE: next_pulseMode = writedata[NUM_CH-1:0];
        clock_seq_pkg::OFS_SYSREF_TIMER: next_timer = writedata[11:0];
        clock_seq_pkg::OFS_PULSE_COUNT: next_pulseCount = writedata[2:0];
        default: next_restart = restart;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata <= '0;
      restart <= 1'b0;
      reseedPulse <= 1'b0;
      pulsePulse <= 1'b0;
      chanEn <= '0;
      syncEn <= '0;
      pulseMode <= '0;
      timer <= clock_seq_pkg::TIMER_RESET;
      pulseCount <= clock_seq_pkg::PULSE_COUNT_RESET;
    end else if (ce) begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      restart <= next_restart;
      reseedPulse <= next_reseedPulse;
      pulsePulse <= next_pulsePulse;
      chanEn <= next_chanEn;
      syncEn <= next_syncEn;
      pulseMode <= next_pulseMode;
      timer <= next_timer;
      pulseCount <= next_pulseCount;
    end
  end

  // ----------------------------------------
  // Reference clock presence
  // ----------------------------------------
  logic refMeta, refSync, refPrev;
  logic [6:0] refIdle, next_refIdle;
  logic refPresent;
  always_comb begin
    next_refIdle = (refSync && !refPrev) ? '0 :
      (refPresent ? refIdle + 1'b1 : refIdle);
    refPresent = refIdle < 7'(clock_seq_pkg::REF_LOSS_CYC);
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
      refPrev <= 1'b0;
      refIdle <= 7'(clock_seq_pkg::REF_LOSS_CYC);
    end else if (ce) begin
      refMeta <= refClk;
      refSync <= refMeta;
      refPrev <= refSync;
      refIdle <= next_refIdle;
    end
  end

  // ----------------------------------------
  // Calibration and lock
  // ----------------------------------------
  cal_state_t state, next_state;
  logic [11:0] pll2Cnt, next_pll2Cnt;
  logic [31:0] pll1Cnt, next_pll1Cnt;
  logic pll1Lock;
  always_comb begin
    next_state = state;
    next_pll2Cnt = pll2Cnt;
    next_pll1Cnt = pll1Cnt;
    unique case (state)
      ST_HOLD: begin
        // Lock counters and state machine held while restart bit is 1
        next_pll2Cnt = '0;
        next_pll1Cnt = '0;
        if (!restart) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        next_pll2Cnt = pll2Cnt + 1'b1;
        if (pll2Cnt == 12'(clock_seq_pkg::PLL2_LOCK_CYC - 1)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_pll2Cnt = pll2Cnt;
    endcase
    if (state != ST_HOLD) begin
      // PLL1 runs in parallel and needs its reference; loss restarts acquisition
      if (!refPresent) begin
        next_pll1Cnt = '0;
      end else if (!pll1Lock) begin
        next_pll1Cnt = pll1Cnt + 1'b1;
      end
    end
    if (restart) begin
      next_state = ST_HOLD;
    end
  end
  assign pll1Lock = pll1Cnt >= 32'(PLL1_LOCK_CYCLES);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= ST_HOLD;
      pll2Cnt <= '0;
      pll1Cnt <= '0;
    end else if (ce) begin
      state <= next_state;
      pll2Cnt <= next_pll2Cnt;
      pll1Cnt <= next_pll1Cnt;
    end
  end

  // ----------------------------------------
  // SYSREF period and phase status
  // ----------------------------------------
  logic [11:0] perCnt, next_perCnt;
  logic [2:0] settle, next_settle;
  logic phaseOk, next_phaseOk;
  logic valid, next_valid;
  logic perTick;
  always_comb begin
    perTick = (perCnt >= timer - 1'b1) || (timer == '0);
    next_perCnt = (perTick || reseedPulse) ? '0 : perCnt + 1'b1;
    next_settle = settle;
    next_phaseOk = phaseOk;
    if (state != ST_RUN || next_state != ST_RUN) begin
      // Leaving lock drops phase status on the same edge, so valid never outlives lock
      next_settle = '0;
      next_phaseOk = 1'b0;
    end else if (reseedPulse) begin
      next_settle = '0;
      next_phaseOk = 1'b0;
    end else if (perTick && !phaseOk) begin
      next_settle = settle + 1'b1;
      if (settle == 3'(clock_seq_pkg::PHASE_SETTLE_PERIODS - 1)) begin
        next_phaseOk = 1'b1;
      end
    end
    next_valid = next_phaseOk && (state == ST_RUN);
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      perCnt <= '0;
      settle <= '0;
      phaseOk <= 1'b0;
      valid <= 1'b0;
      generalOutputPin <= 1'b0;
      sysrefOut <= '0;
    end else if (ce) begin
      perCnt <= next_perCnt;
      settle <= next_settle;
      phaseOk <= next_phaseOk;
      valid <= next_valid;
      generalOutputPin <= next_valid;
      sysrefOut <= bus.sysref;
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[clock_seq_pkg::STS_PLL2_LOCK] = (state == ST_RUN);
    statusWord[clock_seq_pkg::STS_PLL1_LOCK] = pll1Lock && (state != ST_HOLD);
    statusWord[clock_seq_pkg::STS_PHASE_OK] = phaseOk;
    statusWord[clock_seq_pkg::STS_SYSREF_VALID] = valid;
    statusWord[clock_seq_pkg::STS_REF_PRESENT] = refPresent;
  end

  // Channels are silenced and cannot be reseeded until PLL2 has locked
  assign bus.reseed = reseedPulse && (state == ST_RUN);
  assign bus.pulseReq = pulsePulse && (state == ST_RUN);
  assign bus.timer = timer;
  assign bus.pulseCount = pulseCount;
  assign bus.chanEn = (state == ST_RUN) ? chanEn : '0;
  assign bus.syncEn = syncEn;
  assign bus.pulseMode = pulseMode;

  sysref_channel_bank #(.NUM_CH(NUM_CH)) u_bank (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .bus(bus.bank)
  );
endmodule // clock_init_sequencer

// file: ref_clock_source.sv
// Purpose: Far-side reference clock feeding the sequencer link input
// Assumes: 160 ns period, phase unrelated to core_clk
// Notes: Stands still low while disabled, as a lost reference would
`timescale 1ns/1ns
module ref_clock_source (
  input wire logic enable,
  output logic refClk
);
  initial begin
    refClk = 1'b0;
    #7;
    forever begin
      #80;
      refClk = enable ? ~refClk : 1'b0;
    end
  end
endmodule  // ref_clock_source

// file: clock_init_monitor.sv
// Purpose: Bus handshake and lock timing checks at the sequencer ports
// Assumes: ce held high during checked traffic
// Notes: Lock timing is measured from the last restart bit change
`timescale 1ns/1ns
module clock_init_monitor #(
  parameter int NUM_CH = 14,
  parameter int PLL1_LOCK_CYCLES = clock_seq_pkg::PLL1_LOCK_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [NUM_CH-1:0] sysrefOut,
  input wire logic generalOutputPin
);
  localparam int LO = clock_seq_pkg::PLL2_LOCK_CYC - 5;
  localparam int HI = clock_seq_pkg::PLL2_LOCK_CYC + 5;
  logic hold, next_hold, ctlWr, stsAns;
  logic [31:0] since, next_since;
  always_comb begin
    ctlWr = write && !waitrequest && address == clock_seq_pkg::OFS_CONTROL;
    stsAns = read && !waitrequest && address == clock_seq_pkg::OFS_STATUS;
    next_hold = ctlWr ? writedata[clock_seq_pkg::CTL_RESTART] : hold;
    next_since = (next_hold != hold) ? 32'h0000_0000 : since + 32'h0000_0001;
  end
  always_ff @(posedge core_clk) begin
    hold <= rstn ? next_hold : 1'b0;
    since <= rstn ? next_since : 32'h0000_0000;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_wait_answer: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer held longer than one cycle");
  a_answer_asked: assert property (!waitrequest |-> read || write)
    else $error("answer without request");
  a_unmapped_zero: assert property (!waitrequest && read && address > 8'h18 |-> readdata == 0)
    else $error("unmapped read not zero");
  a_valid_phase_lock: assert property (stsAns |-> readdata[3] == (readdata[2] && readdata[0]))
    else $error("valid flag disagrees with phase and lock");
  a_pll2_lock_time: assert property (stsAns && !hold && (since < LO || since > HI)
    |-> readdata[0] == (since > HI)) else $error("second loop lock at wrong time");
  a_pll1_not_early: assert property (stsAns && readdata[1] |-> since >= PLL1_LOCK_CYCLES)
    else $error("first loop lock too early");
  a_sysref_quiet: assert property (since >= 4 && (hold || since < LO) |-> sysrefOut == 0)
    else $error("sysref active before lock");
  a_reseed_clears: assert property (ctlWr && writedata[1] && !hold && since > HI
    |-> ##[0:4] !generalOutputPin) else $error("reseed left valid flag set");
  c_reseed: cover property (ctlWr && writedata[1] && since > HI);
  c_pulse: cover property (ctlWr && writedata[2]);
  c_valid: cover property ($rose(generalOutputPin));
endmodule  // clock_init_monitor
bind clock_init_sequencer clock_init_monitor #(.NUM_CH(NUM_CH),
  .PLL1_LOCK_CYCLES(PLL1_LOCK_CYCLES)) u_mon (.core_clk(core_clk), .rstn(rstn), .ce(ce),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .sysrefOut(sysrefOut), .generalOutputPin(generalOutputPin));

// file: tb_clock_chip_init_resync_sequencer.sv
// Purpose: Self-checking bench for start-up, resync and shutdown sequence
// Assumes: SYSREF timer 16 cycles, shortened first loop lock count
// Notes: Bus waits are bounded by the global cycle ceiling
`timescale 1ns/1ns
module tb_clock_chip_init_resync_sequencer;
  localparam int P1 = 200;
  logic core_clk, rstn, ce, read, write, refEn, refClk, waitrequest, generalOutputPin, prev;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q, seed;
  logic [13:0] sysrefOut;
  int fails = 0, comparisons = 0, cyc = 0, t, k, n;
  clock_init_sequencer #(.NUM_CH(14), .PLL1_LOCK_CYCLES(P1)) u_dut (.core_clk(core_clk),
    .rstn(rstn), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .refClk(refClk),
    .sysrefOut(sysrefOut), .generalOutputPin(generalOutputPin));
  ref_clock_source u_ref (.enable(refEn), .refClk(refClk));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] width_mask(input logic [7:0] a);
    if (a == clock_seq_pkg::OFS_SYSREF_TIMER) return 32'h0000_0FFF;
    if (a == clock_seq_pkg::OFS_PULSE_COUNT) return 32'h0000_0007;
    return 32'h0000_3FFF;
  endfunction
  initial begin
    seed = 32'h0000_3ef0;
    {rstn, read, write, refEn, address, writedata} = '0;
    ce = 1'b1;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    bus(1'b0, clock_seq_pkg::OFS_SYSREF_TIMER, 32'h0000_0000, q);
    check(q, 32'h0000_0100);
    bus(1'b0, clock_seq_pkg::OFS_PULSE_COUNT, 32'h0000_0000, q);
    check(q, 32'h0000_0001);
    check(32'({sysrefOut, generalOutputPin}), 32'h0000_0000);
    for (int a = 4; a <= 20; a += 4) begin
      seed = xs(seed);
      bus(1'b1, 8'(a), seed, q);
      bus(1'b0, 8'(a), 32'h0000_0000, q);
      check(q, seed & width_mask(8'(a)));
    end
    bus(1'b1, 8'h1C, seed, q);
    bus(1'b0, 8'h1C, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    // Restart with the reference running, then time second loop lock
    refEn <= 1'b1;
    // Settle wait shortened for simulation
    repeat (16) @(posedge core_clk);
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0001, q);
    bus(1'b0, clock_seq_pkg::OFS_CONTROL, 32'h0000_0000, q);
    check(q, 32'h0000_0001);
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0000, q);
    t = cyc;
    q = '0;
    while (q[0] !== 1'b1) bus(1'b0, clock_seq_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(32'(cyc - t >= 2495 && cyc - t <= 2512), 32'h0000_0001);
    check(32'(q[1]), 32'h0000_0001);
    bus(1'b1, clock_seq_pkg::OFS_SYSREF_TIMER, 32'h0000_0010, q);
    bus(1'b1, clock_seq_pkg::OFS_CHAN_ENABLE, 32'h0000_3FFF, q);
    bus(1'b1, clock_seq_pkg::OFS_SYNC_ENABLE, 32'h0000_3FFF, q);
    bus(1'b1, clock_seq_pkg::OFS_PULSE_MODE, 32'h0000_0000, q);
    // Let phase status come up first so that the reseed visibly clears it
    repeat (6 * 16 + 8) @(posedge core_clk);
    bus(1'b0, clock_seq_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(32'(q[2]), 32'h0000_0001);
    t = cyc;
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0002, q);
    bus(1'b0, clock_seq_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(32'(q[2]), 32'h0000_0000);
    repeat (6 * 16 + 8) @(posedge core_clk);
    bus(1'b0, clock_seq_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(32'(q[3:2]), 32'h0000_0003);
    check(32'(generalOutputPin), 32'h0000_0001);
    check(32'(&sysrefOut | ~|sysrefOut), 32'h0000_0001);
    // Half-period shifted reseed on channel 0 only
    bus(1'b1, clock_seq_pkg::OFS_SYNC_ENABLE, 32'h0000_0001, q);
    while ((cyc - t) % 16 != 8) @(posedge core_clk);
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0002, q);
    repeat (40) @(posedge core_clk);
    k = 0;
    repeat (16) begin
      @(posedge core_clk);
      if (sysrefOut[0] !== sysrefOut[1] && sysrefOut[1] === sysrefOut[2]) k++;
    end
    check(32'(k), 32'h0000_0010);
    // Pulse chain on one channel after the required wait
    seed = xs(seed);
    n = 1 + int'(seed % 7);
    bus(1'b1, clock_seq_pkg::OFS_PULSE_MODE, 32'h0000_0008, q);
    bus(1'b1, clock_seq_pkg::OFS_PULSE_COUNT, 32'(n), q);
    bus(1'b1, clock_seq_pkg::OFS_SYNC_ENABLE, 32'h0000_3FFF, q);
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0002, q);
    repeat (20 * 16) @(posedge core_clk);
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0004, q);
    k = 0;
    prev = 1'b1;
    repeat (160) begin
      @(posedge core_clk);
      if (sysrefOut[3] === 1'b1 && prev === 1'b0) k++;
      prev = sysrefOut[3];
    end
    check(32'(k), 32'(n));
    bus(1'b1, clock_seq_pkg::OFS_CHAN_ENABLE, 32'h0000_0000, q);
    repeat (8) @(posedge core_clk);
    check(32'(sysrefOut), 32'h0000_0000);
    // Restart while locked must drop every lock and phase flag at once
    bus(1'b1, clock_seq_pkg::OFS_CONTROL, 32'h0000_0001, q);
    bus(1'b0, clock_seq_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(32'(q[3:0]), 32'h0000_0000);
    refEn <= 1'b0;
    repeat (100) @(posedge core_clk);
    bus(1'b0, clock_seq_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(32'(q[4]), 32'h0000_0000);
    report_and_stop();
  end
endmodule  // tb_clock_chip_init_resync_sequencer
